// ### verilog/mstc_cfg.svh
// Purpose: constants of the motor speed and torque command block
// Assumes: 50 MHz REF_CLK; speeds in r/min, torque in percent, times in 0.1 s
// Notes: analog voltages arrive as millivolts (0..10000)
`ifndef MSTC_CFG_SVH
`define MSTC_CFG_SVH
`define MSTC_CLK_HZ 50000000
`define MSTC_N_ENTRIES 16
`define MSTC_SPD_MIN 13'h0032
`define MSTC_SPD_MAX 13'h0fa0
`define MSTC_SPD_DEF 13'h0032
`define MSTC_TRQ_MAX 9'h12c
`define MSTC_TRQ_DEF 9'h12c
`define MSTC_TIME_MAX 8'h96
`define MSTC_TIME_DEF 8'h05
`define MSTC_RATED_SPD 3000
`define MSTC_TIME_UNIT_MS 100
// one ramp step of 1 r/min takes unit_time/rated_speed: 100 ms / 3000 = 33.33 us
`define MSTC_STEP_CYC ((`MSTC_CLK_HZ / 1000) * `MSTC_TIME_UNIT_MS / `MSTC_RATED_SPD)
`define MSTC_SGAIN_DEF 12'h352
`define MSTC_SGAIN_MAX 12'hfa0
`define MSTC_SOFS_DEF 12'sh000
`define MSTC_SOFS_LIM 2000
`define MSTC_SUPPER_DEF 13'h0fa0
`define MSTC_SLOWER_DEF 13'h0032
`define MSTC_TGAIN_DEF 9'h041
`define MSTC_TOFS_DEF 9'sh000
`define MSTC_TOFS_LIM 150
`define MSTC_TAMAX_DEF 9'h12c
`define MSTC_DIR_DEF 1'b1
`define MSTC_SRC_ANALOG_ENTRY 4'h1
`define MSTC_TLE_N 2
`endif

// ### verilog/mstc_pkg.sv
// Purpose: types of the motor speed and torque command block
// Assumes: mstc_cfg.svh gives the numbers
// Notes: none
package mstc_pkg;
	// one stored operation data entry
	typedef struct packed {
		logic [12:0] speed;
		logic [8:0] torque;
		logic [7:0] accel;
		logic [7:0] decel;
	} mstc_entry_t;
	// analog scaling settings
	typedef struct packed {
		logic [11:0] spd_gain;
		logic signed [11:0] spd_ofs;
		logic [12:0] spd_upper;
		logic [12:0] spd_lower;
		logic [8:0] trq_gain;
		logic signed [8:0] trq_ofs;
		logic [8:0] trq_amax;
	} mstc_scale_t;
	// command source selection
	typedef enum logic [1:0] {
		MSTC_SRC_DIGITAL = 2'b00,
		MSTC_SRC_SPD_E1 = 2'b01,
		MSTC_SRC_SPD_ALL = 2'b10,
		MSTC_SRC_TRQ_AN = 2'b11
	} mstc_src_t;
	// run state of the motor command
	typedef enum logic [1:0] {
		MSTC_ST_IDLE = 2'b00,
		MSTC_ST_RUN = 2'b01,
		MSTC_ST_STOP = 2'b10
	} mstc_state_t;
endpackage : mstc_pkg

// ### verilog/mstc_analog.sv
// Purpose: scales the analog inputs into speed and torque limit values
// Assumes: voltages in millivolts, 0..10000
// Notes: results are registered
`timescale 1ns/1ns
`default_nettype none
`include "mstc_cfg.svh"
module mstc_analog (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// settings and inputs
	input wire mstc_pkg::mstc_scale_t scale,
	input wire logic [13:0] spd_mv,
	input wire logic [13:0] trq_mv,
	// scaled results
	output logic [12:0] spd_cmd,
	output logic [8:0] trq_lim
);
	import mstc_pkg::*;
	// clamp a signed value into lo..hi
	function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		if (v < lo) begin
			clamp = lo;
		end else if (v > hi) begin
			clamp = hi;
		end else begin
			clamp = v;
		end
	endfunction : clamp
	// gain times volts (mV/1000) plus offset
	wire logic signed [31:0] spd_raw;
	wire logic signed [31:0] trq_raw;
	wire logic signed [31:0] spd_cl;
	wire logic signed [31:0] trq_cl;
	assign spd_raw = $signed({4'h0, 28'(32'(scale.spd_gain) * 32'(spd_mv) / 1000)})
		+ 32'(scale.spd_ofs);
	assign trq_raw = $signed({4'h0, 28'(32'(scale.trq_gain) * 32'(trq_mv) / 1000)})
		+ 32'(scale.trq_ofs);
	// speed bounded by lower and upper limit
	assign spd_cl = clamp(spd_raw, 32'(scale.spd_lower), 32'(scale.spd_upper));
	// torque capped by analog maximum
	assign trq_cl = clamp(trq_raw, 32'sd0, 32'(scale.trq_amax));
	// register the results
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			spd_cmd <= `MSTC_SPD_DEF;
			trq_lim <= `MSTC_TRQ_DEF;
		end else begin
			spd_cmd <= spd_cl[12:0];
			trq_lim <= trq_cl[8:0];
		end
	end
endmodule : mstc_analog
`default_nettype wire

// ### verilog/mstc_ramp.sv
// Purpose: ramps the present speed toward a target at a set rate
// Assumes: tick pulses once every ramp tick period
// Notes: time of 0 ramps in one step per clock
`timescale 1ns/1ns
`default_nettype none
`include "mstc_cfg.svh"
module mstc_ramp (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// ramp control
	input wire logic [12:0] target,
	input wire logic [7:0] time_set,
	input wire logic tick,
	// present speed
	output logic [12:0] speed
);
	import mstc_pkg::*;
	// ticks counted per 1 r/min step, equal to the time figure
	logic [7:0] cnt_r;
	wire logic step;
	assign step = (time_set == 8'h00) || (tick && cnt_r + 8'h01 >= time_set);
	// step counter and speed register
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_r <= 8'h00;
			speed <= 13'h0000;
		end else begin
			if (step) begin
				cnt_r <= 8'h00;
				if (speed < target) begin
					speed <= speed + 13'h0001;
				end else if (speed > target) begin
					speed <= speed - 13'h0001;
				end
			end else if (tick) begin
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule : mstc_ramp
`default_nettype wire

// ### verilog/mstc_top.sv
// Purpose: command logic of a brushless motor driver
// Assumes: inputs synchronous to REF_CLK; analog inputs in millivolts
// Notes: the motor stage sees speed, direction and a torque cap
//
// Contract
// - sixteen entries: speed, torque, accel, decel
// - forward input runs clockwise, release decelerates
// - reverse input runs counterclockwise, release decelerates
// - both inputs on: decelerate to stop
// - direction mapping follows direction parameter
// - two-wire default, three-wire selectable
// - analog speed is gain times voltage
// - analog speed offset added, plus/minus 2000
// - speed bounded by upper limit
// - speed bounded by lower limit
// - entry one takes speed from analog
// - panel speed applied at next start (code: start_spd_r follows selected speed every clock)
// - enable on: cap torque at limit
// - enable off: cap is instantaneous maximum
// - enable absent is on; several are ANDed
// - limit reached output when torque reaches cap (code: only while enable on; stays off when enable is off)
// - source value three: analog torque limit
// - analog torque gain in percent per volt
// - analog torque offset added, plus/minus 150
// - analog torque capped at maximum setting
// - four select bits form entry number
// - direction parameter: 0 ccw, 1 cw
// - ramp time spans standstill to 3000
`timescale 1ns/1ns
`default_nettype none
`include "mstc_cfg.svh"
module mstc_top (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// run inputs
	input wire logic FORWARD_RUN_INPUT,
	input wire logic REVERSE_RUN_INPUT,
	input wire logic THREE_WIRE_MODE,
	// data selection
	input wire logic DATA_SELECT_BIT0,
	input wire logic DATA_SELECT_BIT1,
	input wire logic DATA_SELECT_BIT2,
	input wire logic DATA_SELECT_BIT3,
	// entry write port (panel confirm)
	input wire logic ENTRY_WE,
	input wire logic [3:0] ENTRY_IDX,
	input wire mstc_pkg::mstc_entry_t ENTRY_WDATA,
	// settings
	input wire logic DIR_PARAM,
	input wire mstc_pkg::mstc_src_t CMD_SRC,
	input wire mstc_pkg::mstc_scale_t SCALE,
	// analog inputs in millivolts
	input wire logic [13:0] SPEED_MV,
	input wire logic [13:0] TORQUE_MV,
	// torque limit enable terminals and their assignment
	input wire logic [`MSTC_TLE_N-1:0] TORQUE_LIMIT_ENABLE_INPUT,
	input wire logic [`MSTC_TLE_N-1:0] TLE_ASSIGNED,
	// measured motor torque in percent
	input wire logic [8:0] MOTOR_TORQUE,
	// motor stage command
	output logic [12:0] SPEED_OUT_CMD,
	output logic DIR_CW,
	output logic RUNNING,
	output logic [8:0] TORQUE_CAP,
	output logic TORQUE_LIMIT_REACHED_OUTPUT,
	output mstc_pkg::mstc_state_t STATE
);
	import mstc_pkg::*;
	// operation data table
	mstc_entry_t table_r [0:`MSTC_N_ENTRIES-1];
	// run state and latched run direction
	mstc_state_t state_r;
	mstc_state_t state_nxt;
	logic fwd_run_r;
	logic start_hold_r;
	logic [12:0] start_spd_r;
	logic [15:0] tick_cnt_r;
	logic tick;
	// selected entry from select bits
	wire logic [3:0] sel;
	assign sel = {DATA_SELECT_BIT3, DATA_SELECT_BIT2, DATA_SELECT_BIT1, DATA_SELECT_BIT0};
	wire mstc_entry_t ent;
	assign ent = table_r[sel];
	// analog conversions
	wire logic [12:0] an_spd;
	wire logic [8:0] an_trq;
	mstc_analog u_analog (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.scale(SCALE),
		.spd_mv(SPEED_MV),
		.trq_mv(TORQUE_MV),
		.spd_cmd(an_spd),
		.trq_lim(an_trq)
	);
	// speed source: analog for entry one, or all entries
	wire logic use_an_spd;
	assign use_an_spd = (CMD_SRC == MSTC_SRC_SPD_ALL) ||
		(CMD_SRC == MSTC_SRC_SPD_E1 && sel == `MSTC_SRC_ANALOG_ENTRY);
	wire logic [12:0] dig_spd;
	// stored digital speed bounded by the limits
	assign dig_spd = (ent.speed > SCALE.spd_upper) ? SCALE.spd_upper :
		(ent.speed < SCALE.spd_lower) ? SCALE.spd_lower : ent.speed;
	wire logic [12:0] sel_spd;
	assign sel_spd = use_an_spd ? an_spd : dig_spd;
	// run request decode: 2-wire levels, 3-wire start + direction select
	wire logic forward_run_input;
	wire logic reverse_run_input;
	wire logic req;
	assign forward_run_input = FORWARD_RUN_INPUT;
	assign reverse_run_input = REVERSE_RUN_INPUT;
	// in three-wire mode forward acts as start and reverse as direction select
	assign req = THREE_WIRE_MODE ? forward_run_input : (forward_run_input ^ reverse_run_input);
	wire logic req_fwd;
	assign req_fwd = THREE_WIRE_MODE ? !reverse_run_input : forward_run_input;
	// inputs are taken at once; the controller holds them 10 ms and gaps 10 ms
	// so no filter is needed here
	// ramp tick divider: one tick per 1 r/min step of a 0.1 s time
	wire logic tick_wrap;
	assign tick_wrap = (tick_cnt_r == 16'(`MSTC_STEP_CYC - 1));
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			tick_cnt_r <= 16'h0000;
			tick <= 1'b0;
		end else begin
			tick_cnt_r <= tick_wrap ? 16'h0000 : tick_cnt_r + 16'h0001;
			tick <= tick_wrap;
		end
	end
	// table write on panel confirm, defaults at reset
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < `MSTC_N_ENTRIES; i++) begin
				table_r[i] <= '{`MSTC_SPD_DEF, `MSTC_TRQ_DEF, `MSTC_TIME_DEF,
					`MSTC_TIME_DEF};
			end
		end else if (ENTRY_WE) begin
			table_r[ENTRY_IDX] <= ENTRY_WDATA;
		end
	end
	// run state machine
	wire logic [12:0] cur_spd;
	always_comb begin
		state_nxt = state_r;
		case (state_r)
			MSTC_ST_IDLE: begin
				if (req) begin
					state_nxt = MSTC_ST_RUN;
				end
			end
			MSTC_ST_RUN: begin
				// release, both on, or a direction change: decelerate
				if (!req || req_fwd != fwd_run_r) begin
					state_nxt = MSTC_ST_STOP;
				end
			end
			MSTC_ST_STOP: begin
				if (cur_spd == 13'h0000) begin
					state_nxt = MSTC_ST_IDLE;
				end else if (req && req_fwd == fwd_run_r) begin
					state_nxt = MSTC_ST_RUN;
				end
			end
			default: begin
				state_nxt = MSTC_ST_IDLE;
			end
		endcase
	end
	// state and selected speed registered every clock; run direction latched at start from idle
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			state_r <= MSTC_ST_IDLE;
			fwd_run_r <= 1'b1;
			start_hold_r <= 1'b0;
			start_spd_r <= 13'h0000;
		end else begin
			state_r <= state_nxt;
			if (state_r == MSTC_ST_IDLE && req) begin
				fwd_run_r <= req_fwd;
				start_hold_r <= 1'b1;
			end
			start_spd_r <= sel_spd;
		end
	end
	// speed target: zero unless running; ramp time from selected entry
	wire logic [12:0] target;
	wire logic [7:0] ramp_time;
	assign target = (state_r == MSTC_ST_RUN) ? start_spd_r : 13'h0000;
	assign ramp_time = (state_r == MSTC_ST_RUN && cur_spd < target) ? ent.accel :
		ent.decel;
	mstc_ramp u_ramp (
		.clk(REF_CLK),
		.rst_n(RST_N),
		.target(target),
		.time_set(ramp_time),
		.tick(tick),
		.speed(cur_spd)
	);
	// direction mapping: forward means cw when parameter is 1
	wire logic dir_cw;
	assign dir_cw = fwd_run_r ? DIR_PARAM : !DIR_PARAM;
	// torque enable: unassigned terminals count as on, assigned ones ANDed
	wire logic tl_en;
	assign tl_en = &(TORQUE_LIMIT_ENABLE_INPUT | ~TLE_ASSIGNED);
	// torque limit source
	wire logic [8:0] lim;
	assign lim = (CMD_SRC == MSTC_SRC_TRQ_AN) ? an_trq : ent.torque;
	wire logic [8:0] cap;
	assign cap = tl_en ? lim : `MSTC_TRQ_MAX;
	// limit reached: unreliable below 20 percent, reported as is
	wire logic reached;
	assign reached = tl_en && (MOTOR_TORQUE >= lim);
	// registered outputs
	always_ff @(posedge REF_CLK) begin
		if (!RST_N) begin
			SPEED_OUT_CMD <= 13'h0000;
			DIR_CW <= `MSTC_DIR_DEF;
			RUNNING <= 1'b0;
			TORQUE_CAP <= `MSTC_TRQ_MAX;
			TORQUE_LIMIT_REACHED_OUTPUT <= 1'b0;
			STATE <= MSTC_ST_IDLE;
		end else begin
			SPEED_OUT_CMD <= cur_spd;
			DIR_CW <= dir_cw;
			RUNNING <= (cur_spd != 13'h0000);
			TORQUE_CAP <= cap;
			TORQUE_LIMIT_REACHED_OUTPUT <= reached;
			STATE <= state_r;
		end
	end
endmodule : mstc_top
`default_nettype wire

// ### tb/mstc_top_properties.sv
// Purpose: port checks of the speed and torque command block
// Assumes: one clock domain, synchronous active low reset
// Notes: bound to mstc_top below
`timescale 1ns/1ns
`default_nettype none
`include "mstc_cfg.svh"
module mstc_prop
	import mstc_pkg::*;
(
	// clock and reset
	input wire logic REF_CLK,
	input wire logic RST_N,
	// run inputs and settings
	input wire logic FORWARD_RUN_INPUT,
	input wire logic REVERSE_RUN_INPUT,
	input wire logic THREE_WIRE_MODE,
	input wire logic DIR_PARAM,
	input wire logic [`MSTC_TLE_N-1:0] TORQUE_LIMIT_ENABLE_INPUT,
	input wire logic [`MSTC_TLE_N-1:0] TLE_ASSIGNED,
	input wire logic [8:0] MOTOR_TORQUE,
	// motor stage command
	input wire logic [12:0] SPEED_OUT_CMD,
	input wire logic DIR_CW,
	input wire logic RUNNING,
	input wire logic [8:0] TORQUE_CAP,
	input wire logic TORQUE_LIMIT_REACHED_OUTPUT,
	input wire mstc_pkg::mstc_state_t STATE
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!RST_N);
	wire logic fw; // forward alone, two-wire
	wire logic rv; // reverse alone, two-wire
	wire logic tle_on; // every assigned enable terminal on
	assign fw = !THREE_WIRE_MODE && FORWARD_RUN_INPUT && !REVERSE_RUN_INPUT;
	assign rv = !THREE_WIRE_MODE && !FORWARD_RUN_INPUT && REVERSE_RUN_INPUT;
	assign tle_on = (TORQUE_LIMIT_ENABLE_INPUT & TLE_ASSIGNED) == TLE_ASSIGNED;
	property p_both;
		(!THREE_WIRE_MODE && FORWARD_RUN_INPUT && REVERSE_RUN_INPUT) [*4] |-> STATE != MSTC_ST_RUN;
	endproperty
	a_both: assert property (p_both) else $error("run with both inputs on");
	property p_rel;
		(!THREE_WIRE_MODE && !FORWARD_RUN_INPUT && !REVERSE_RUN_INPUT) [*4] |-> STATE != MSTC_ST_RUN;
	endproperty
	a_rel: assert property (p_rel) else $error("run after release");
	property p_fdir;
		(fw && $stable(DIR_PARAM)) [*4] ##0 STATE == MSTC_ST_RUN |-> DIR_CW == DIR_PARAM;
	endproperty
	a_fdir: assert property (p_fdir) else $error("forward direction wrong");
	property p_rdir;
		(rv && $stable(DIR_PARAM)) [*4] ##0 STATE == MSTC_ST_RUN |-> DIR_CW != DIR_PARAM;
	endproperty
	a_rdir: assert property (p_rdir) else $error("reverse direction wrong");
	property p_cap_off;
		(!tle_on) [*3] |-> TORQUE_CAP == 9'h12c;
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("cap not maximum");
	property p_rch_on;
		(tle_on && MOTOR_TORQUE >= TORQUE_CAP) [*3] |-> TORQUE_LIMIT_REACHED_OUTPUT;
	endproperty
	a_rch_on: assert property (p_rch_on) else $error("limit reach missed");
	property p_rch_off;
		(MOTOR_TORQUE < TORQUE_CAP) [*3] |-> !TORQUE_LIMIT_REACHED_OUTPUT;
	endproperty
	a_rch_off: assert property (p_rch_off) else $error("limit reach false");
	property p_step;
		(SPEED_OUT_CMD - $past(SPEED_OUT_CMD)) inside {13'h0000, 13'h0001, 13'h1fff};
	endproperty
	a_step: assert property (p_step) else $error("speed step too big");
	property p_idle;
		(STATE == MSTC_ST_IDLE && SPEED_OUT_CMD == 13'h0000) [*2] |-> !RUNNING;
	endproperty
	a_idle: assert property (p_idle) else $error("running at standstill");
	c_stop: cover property (STATE == MSTC_ST_RUN ##1 STATE == MSTC_ST_STOP);
	c_rch: cover property (TORQUE_LIMIT_REACHED_OUTPUT);
	c_both: cover property (FORWARD_RUN_INPUT && REVERSE_RUN_INPUT);
endmodule : mstc_prop
bind mstc_top mstc_prop u_prop (.REF_CLK(REF_CLK), .RST_N(RST_N),
	.FORWARD_RUN_INPUT(FORWARD_RUN_INPUT), .REVERSE_RUN_INPUT(REVERSE_RUN_INPUT),
	.THREE_WIRE_MODE(THREE_WIRE_MODE), .DIR_PARAM(DIR_PARAM),
	.TORQUE_LIMIT_ENABLE_INPUT(TORQUE_LIMIT_ENABLE_INPUT), .TLE_ASSIGNED(TLE_ASSIGNED),
	.MOTOR_TORQUE(MOTOR_TORQUE), .SPEED_OUT_CMD(SPEED_OUT_CMD), .DIR_CW(DIR_CW),
	.RUNNING(RUNNING), .TORQUE_CAP(TORQUE_CAP),
	.TORQUE_LIMIT_REACHED_OUTPUT(TORQUE_LIMIT_REACHED_OUTPUT), .STATE(STATE));
`default_nettype wire

// ### tb/mstc_ctrl_model.sv
// Purpose: external controller at the run input terminals
// Assumes: requests change at the falling edge
// Notes: HOLD_CYC stands in for the 10 ms hold and gap
`timescale 1ns/1ns
`default_nettype none
module mstc_ctrl_model #(
	parameter int HOLD_CYC = 500000
) (
	// clock
	input wire logic clk,
	// wanted levels: bit 1 forward, bit 0 reverse
	input wire logic [1:0] req,
	// run terminals
	output var logic forward_run_input,
	output var logic reverse_run_input
);
	int cnt = 0; // cycles since the last terminal change
	initial begin
		forward_run_input = 1'b0;
		reverse_run_input = 1'b0;
	end
	// a level may change only after it has stood long enough
	always @(negedge clk) begin
		cnt <= cnt + 1;
		if (req != {forward_run_input, reverse_run_input} && cnt >= HOLD_CYC) begin
			cnt <= 0;
			// a direction swap passes through an all-off gap
			if ((forward_run_input | reverse_run_input) && req != 2'b00) begin
				{forward_run_input, reverse_run_input} <= 2'b00;
			end else begin
				{forward_run_input, reverse_run_input} <= req;
			end
		end
	end
endmodule : mstc_ctrl_model
`default_nettype wire

// ### tb/testbench.sv
// Purpose: self-checking bench of the speed and torque command block
// Assumes: ramp times of 0 or 0.1 s keep the run short
// Notes: controller hold shortened to 20 cycles
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import mstc_pkg::*;
	// one row: selection, enable terminals, source, voltage, cap, reached
	typedef struct packed {
		logic [3:0] sel; logic [1:0] tin; logic [1:0] tasg;
		mstc_src_t src; logic [13:0] mv; logic [8:0] cap; logic rch;
	} mstc_row_t;
	mstc_row_t rows [8] = '{
		'{4'h3, 2'h3, 2'h3, MSTC_SRC_DIGITAL, 14'h0000, 9'h078, 1'b1},
		'{4'h3, 2'h1, 2'h3, MSTC_SRC_DIGITAL, 14'h0000, 9'h12c, 1'b0},
		'{4'h3, 2'h0, 2'h0, MSTC_SRC_DIGITAL, 14'h0000, 9'h078, 1'b1},
		'{4'h3, 2'h2, 2'h2, MSTC_SRC_DIGITAL, 14'h0000, 9'h078, 1'b1},
		'{4'hc, 2'h3, 2'h3, MSTC_SRC_DIGITAL, 14'h0000, 9'h0c8, 1'b0},
		'{4'h0, 2'h3, 2'h3, MSTC_SRC_DIGITAL, 14'h0000, 9'h12c, 1'b0},
		'{4'h0, 2'h3, 2'h3, MSTC_SRC_TRQ_AN, 14'h07d0, 9'h08c, 1'b1},
		'{4'h0, 2'h3, 2'h3, MSTC_SRC_TRQ_AN, 14'h0fa0, 9'h0fa, 1'b0}};
	logic [12:0] aexp [3] = '{13'h00fa, 13'h00c8, 13'h0064}; // analog speeds
	logic clk = 1'b0, rst_n = 1'b0, tw, we, dp, dcw, rn, rch;
	logic [1:0] req, run, tin, tasg;
	logic [3:0] sel, idx;
	logic [13:0] smv, tmv;
	logic [8:0] mt, cap;
	logic [12:0] spd;
	mstc_entry_t wd;
	mstc_src_t src;
	mstc_scale_t sc;
	mstc_state_t st;
	int err_count = 0, num_checks = 0, cyc = 0;
	mstc_ctrl_model #(.HOLD_CYC(20)) u_ctl (.clk(clk), .req(req), .forward_run_input(run[1]), .reverse_run_input(run[0]));
	mstc_top uut (.REF_CLK(clk), .RST_N(rst_n), .FORWARD_RUN_INPUT(run[1]),
		.REVERSE_RUN_INPUT(run[0]), .THREE_WIRE_MODE(tw), .DATA_SELECT_BIT0(sel[0]),
		.DATA_SELECT_BIT1(sel[1]), .DATA_SELECT_BIT2(sel[2]), .DATA_SELECT_BIT3(sel[3]),
		.ENTRY_WE(we), .ENTRY_IDX(idx), .ENTRY_WDATA(wd), .DIR_PARAM(dp), .CMD_SRC(src),
		.SCALE(sc), .SPEED_MV(smv), .TORQUE_MV(tmv), .TORQUE_LIMIT_ENABLE_INPUT(tin),
		.TLE_ASSIGNED(tasg), .MOTOR_TORQUE(mt), .SPEED_OUT_CMD(spd), .DIR_CW(dcw),
		.RUNNING(rn), .TORQUE_CAP(cap), .TORQUE_LIMIT_REACHED_OUTPUT(rch), .STATE(st));
	initial begin
		forever #10 clk = ~clk;
	end
	// compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_of_test
	// write one entry through the panel confirm port
	task automatic wr(input logic [3:0] i, input mstc_entry_t e);
		@(negedge clk);
		we = 1'b1;
		idx = i;
		wd = e;
		@(negedge clk);
		we = 1'b0;
	endtask : wr
	// wait, bounded, for the ramped speed
	task automatic wait_spd(input logic [12:0] v);
		int n = 0;
		while (spd !== v && n < 3000) begin
			@(negedge clk);
			n++;
		end
	endtask : wait_spd
	// hang guard
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc >= 20000) begin
			err_count++;
			end_of_test();
		end
	end
	initial begin
		req = 2'h0; tw = 1'b0; we = 1'b0; dp = 1'b1; sel = 4'h0; idx = 4'h0; wd = '0;
		src = MSTC_SRC_DIGITAL; smv = 14'h0000; tmv = 14'h0000; tin = 2'h3; tasg = 2'h3;
		mt = 9'h096;
		sc = '{12'h064, 12'sh032, 13'h0fa0, 13'h0032, 9'h041, 9'sh00a, 9'h0fa};
		repeat (12) @(negedge clk);
		chk({spd, dcw, rn, rch}, 16'h0004);
		chk({cap, st}, 16'h04b0);
		rst_n = 1'b1;
		$display("reset done");
		wr(4'h3, '{13'h012c, 9'h078, 8'h00, 8'h00});
		wr(4'hc, '{13'h0064, 9'h0c8, 8'h00, 8'h00});
		wr(4'h5, '{13'h0096, 9'h05a, 8'h00, 8'h01});
		// entry one ramps at once so the analog speed runs stay short
		wr(4'h1, '{13'h0032, 9'h12c, 8'h00, 8'h00});
		foreach (rows[i]) begin
			sel = rows[i].sel; tin = rows[i].tin; tasg = rows[i].tasg;
			src = rows[i].src; tmv = rows[i].mv;
			repeat (6) @(negedge clk);
			chk(cap, rows[i].cap);
			chk(rch, rows[i].rch);
			$display("row %0d done", i);
		end
		src = MSTC_SRC_DIGITAL;
		sel = 4'h3;
		req = 2'h2;
		wait_spd(13'h012c);
		chk(spd, 13'h012c);
		chk({dcw, st}, {1'b1, MSTC_ST_RUN});
		req = 2'h0;
		wait_spd(13'h0000);
		repeat (4) @(negedge clk);
		chk(st, MSTC_ST_IDLE);
		$display("forward run done");
		for (int d = 0; d < 2; d++) begin
			dp = d[0]; sel = 4'hc; req = 2'h1;
			wait_spd(13'h0064);
			chk(dcw, !dp);
			req = 2'h0;
			wait_spd(13'h0000);
			repeat (4) @(negedge clk);
		end
		$display("reverse run done");
		req = 2'h3;
		repeat (40) @(negedge clk);
		chk({spd, st}, {13'h0000, MSTC_ST_IDLE});
		req = 2'h0;
		$display("both inputs done");
		src = MSTC_SRC_SPD_E1;
		sel = 4'h1;
		for (int k = 0; k < 3; k++) begin
			smv = k == 2 ? 14'h0000 : 14'h07d0;
			sc.spd_upper = k == 1 ? 13'h00c8 : 13'h0fa0;
			sc.spd_lower = k == 2 ? 13'h0064 : 13'h0032;
			repeat (30) @(negedge clk);
			req = 2'h2;
			wait_spd(aexp[k]);
			chk(spd, aexp[k]);
			req = 2'h0;
			wait_spd(13'h0000);
		end
		$display("analog speed done");
		src = MSTC_SRC_DIGITAL;
		sel = 4'h5;
		repeat (30) @(negedge clk);
		req = 2'h2;
		wait_spd(13'h0096);
		req = 2'h0;
		// first 1 r/min step lands on a ramp tick; the next is a tick period later
		wait_spd(13'h0095);
		chk(spd, 13'h0095);
		repeat (1500) @(negedge clk);
		chk(spd, 13'h0095);
		sel = 4'h3;
		wait_spd(13'h0000);
		chk(spd, 13'h0000);
		$display("deceleration done");
		// three-wire: forward is start, reverse low selects forward direction
		tw = 1'b1;
		repeat (30) @(negedge clk);
		req = 2'h2;
		wait_spd(13'h012c);
		chk({dcw, st}, {1'b1, MSTC_ST_RUN});
		req = 2'h0;
		wait_spd(13'h0000);
		chk(spd, 13'h0000);
		tw = 1'b0;
		$display("three-wire done");
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
